// File: verilog/emu_inhibit_pkg.sv
// Constants shared by the processor bus end and the memory-side inhibit end.
// Assumes a single 40 MHz system clock and a synchronous active-low reset.
package emu_inhibit_pkg;
  localparam int           REQ_TYPE_W    = 2;
  localparam int           OPT_CODE_W    = 3;
  localparam int           TEST_CTRL_W   = 2;
  localparam int           ADDR_W        = 32;
  localparam int           DATA_W        = 32;
  localparam int           BURST_PAGE_B  = 10;
  localparam logic [1:0]   REQ_TYPE_INSTR_DATA = 2'h0;
  localparam logic [2:0]   OPT_EMU_ACCESS      = 3'h6;
  localparam logic [1:0]   TEST_CTRL_LOAD_TEST = 2'h0;
  localparam logic [1:0]   TEST_CTRL_NORMAL    = 2'h3;
endpackage : emu_inhibit_pkg

// File: verilog/emu_bus_if.sv
// Processor bus between the master end and the memory decode end.
// Assumes both ends share clk_sys_in; no tri-state, enables resolved here.
`timescale 1ns/1ps
interface emu_bus_if;
  import emu_inhibit_pkg::*;
  logic                      req;
  logic                      rd_nwr;
  logic                      burst;
  logic [ADDR_W-1:0]         addr;
  logic [REQ_TYPE_W-1:0]     data_request_type;
  logic [OPT_CODE_W-1:0]     option_code;
  logic [TEST_CTRL_W-1:0]    test_control;
  logic                      locator_pin;
  logic [DATA_W-1:0]         wdata;
  logic [DATA_W-1:0]         mem_rdata;
  logic                      mem_rdata_oe;
  logic                      mem_ready;
  logic                      mem_error;
  logic                      mem_resp_oe;
  modport master (
    output req, rd_nwr, burst, addr, data_request_type, option_code,
           test_control, locator_pin, wdata,
    input  mem_rdata, mem_rdata_oe, mem_ready, mem_error, mem_resp_oe
  );
  modport memory (
    input  req, rd_nwr, burst, addr, data_request_type, option_code,
           test_control, locator_pin, wdata,
    output mem_rdata, mem_rdata_oe, mem_ready, mem_error, mem_resp_oe
  );
endinterface : emu_bus_if

// File: verilog/bus_master_end.sv
// Bus master end: issues single or burst accesses and emulator takeovers.
// Assumes user requests are synchronous to clk_sys_in.
`timescale 1ns/1ps
module bus_master_end
  import emu_inhibit_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_b_in,
  emu_bus_if.master                  bus,
  input  wire logic                  start_in,
  input  wire logic                  rd_nwr_in,
  input  wire logic                  burst_in,
  input  wire logic                  emu_access_in,
  input  wire logic                  takeover_pin_in,
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [DATA_W-1:0]     wdata_in,
  output logic                       busy_out,
  output logic                       done_out,
  output logic                       error_out,
  output logic [DATA_W-1:0]          rdata_out
);
  typedef enum logic [0:0] {IDLE = 1'b0, ACTIVE = 1'b1} mst_state_e;
  mst_state_e              state_q, state_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic                    rd_q, rd_d, burst_q, burst_d, emu_q, emu_d;
  logic                    done_q, done_d, err_q, err_d;
  logic [DATA_W-1:0]       rdata_q, rdata_d;
  logic [DATA_W-1:0]       wdata_q, wdata_d;
  logic                    pin_q, pin_d;
  logic                    ack;

  assign ack = bus.mem_ready | bus.mem_error;

  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    rd_d    = rd_q;
    burst_d = burst_q;
    emu_d   = emu_q;
    wdata_d = wdata_q;
    done_d  = 1'b0;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    pin_d   = takeover_pin_in;
    unique case (state_q)
      IDLE: begin
        if (start_in) begin // New access only from idle
          state_d = ACTIVE;
          addr_d  = addr_in;
          rd_d    = rd_nwr_in; // Direction fixed for whole burst
          burst_d = burst_in;
          emu_d   = emu_access_in;
          wdata_d = wdata_in;
        end
      end
      ACTIVE: begin
        if (ack) begin
          done_d = 1'b1;
          err_d  = bus.mem_error;
          if (rd_q) begin
            rdata_d = bus.mem_rdata;
          end
          // Burst ends at 1K boundary; a new address must follow
          if (burst_q && !bus.mem_error && start_in &&
              (addr_q[BURST_PAGE_B-1:2] != '1)) begin
            addr_d  = addr_q + ADDR_W'(4);
            wdata_d = wdata_in;
          end else begin
            state_d = IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_q <= IDLE;
      addr_q  <= '0;
      rd_q    <= 1'b1;
      burst_q <= 1'b0;
      emu_q   <= 1'b0;
      wdata_q <= '0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
      pin_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      burst_q <= burst_d;
      emu_q   <= emu_d;
      wdata_q <= wdata_d;
      done_q  <= done_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
      pin_q   <= pin_d;
    end
  end

  assign bus.req               = (state_q == ACTIVE);
  assign bus.rd_nwr            = rd_q;
  assign bus.burst             = burst_q;
  assign bus.addr              = addr_q;
  assign bus.wdata             = wdata_q;
  assign bus.data_request_type = REQ_TYPE_INSTR_DATA;
  assign bus.option_code       = emu_q ? OPT_EMU_ACCESS : '0;
  assign bus.test_control      = emu_q ? TEST_CTRL_LOAD_TEST
                                       : TEST_CTRL_NORMAL;
  assign bus.locator_pin       = pin_q;
  assign busy_out              = (state_q == ACTIVE);
  assign done_out              = done_q;
  assign error_out             = err_q;
  assign rdata_out             = rdata_q;
endmodule : bus_master_end

// File: verilog/memory_inhibit_end.sv
// Memory-side select decode with emulator takeover inhibit.
// Assumes the master keeps bus protocol and idles before halt/step.
//
// Functional notes
// - Emulator announces takeover by pin or code
// - Locator pin disables all memory selects
// - Request type 00, option 110 means emulator
// - Emulator access: memories drive no data/response
// - Emulator uses load-test mode, control 00
// - Option 110 counts only with type 00
// - Master gives new address at 1K crossing
// - Bursts never mix reads and writes
// - Drive data only together with ready/error
// - Processor finishes access before halt/step
`timescale 1ns/1ps
module memory_inhibit_end
  import emu_inhibit_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 32'h0000_0000,
  parameter logic [ADDR_W-1:0] ADDR_MASK = 32'hffff_0000
)(
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_b_in,
  emu_bus_if.memory                  bus,
  input  wire logic [DATA_W-1:0]     mem_rdata_in,
  input  wire logic                  mem_fault_in,
  output logic                       mem_select_out,
  output logic                       mem_write_out,
  output logic [ADDR_W-1:0]          mem_addr_out,
  output logic [DATA_W-1:0]          mem_wdata_out,
  output logic                       inhibit_out
);
  typedef enum logic [1:0] {
    MEM_IDLE   = 2'b00,
    MEM_SELECT = 2'b01,
    MEM_ANSWER = 2'b10
  } mem_state_e;

  mem_state_e              state_q;
  mem_state_e              state_d;

  logic                    pin_meta_q;
  logic                    pin_meta_d;
  logic                    pin_sync_q;
  logic                    pin_sync_d;

  logic                    code_hit;
  logic                    inhibit;
  logic                    hit;
  logic                    page_end;
  logic                    more_beats;
  logic                    dir_flip;
  logic                    answer;
  logic                    force_err;

  logic                    sel_q;
  logic                    sel_d;
  logic                    wr_q;
  logic                    wr_d;
  logic                    burst_q;
  logic                    burst_d;
  logic [ADDR_W-1:0]       maddr_q;
  logic [ADDR_W-1:0]       maddr_d;
  logic [DATA_W-1:0]       mwdata_q;
  logic [DATA_W-1:0]       mwdata_d;

  logic                    resp_q;
  logic                    resp_d;
  logic                    err_q;
  logic                    err_d;
  logic [DATA_W-1:0]       rdata_q;
  logic [DATA_W-1:0]       rdata_d;

  // Locator pin comes from off-board test gear
  always_comb begin
    pin_meta_d = bus.locator_pin;
    pin_sync_d = pin_meta_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
    end
  end

  // Either takeover sign inhibits every select
  assign code_hit = (bus.data_request_type == REQ_TYPE_INSTR_DATA)
                  && (bus.option_code == OPT_EMU_ACCESS);
  assign inhibit  = pin_sync_q | code_hit;
  assign hit      = bus.req && ((bus.addr & ADDR_MASK) == BASE_ADDR);
  // Own beat counter stops at the page end
  assign page_end = (maddr_q[BURST_PAGE_B-1:2] == '1);
  assign more_beats = burst_q && bus.req && !err_q && !page_end;
  // Mixed direction inside a burst is answered with error
  assign dir_flip = (bus.rd_nwr == wr_q);

  // Select and beat sequencing
  always_comb begin
    state_d   = state_q;
    sel_d     = sel_q;
    wr_d      = wr_q;
    burst_d   = burst_q;
    maddr_d   = maddr_q;
    mwdata_d  = mwdata_q;
    answer    = 1'b0;
    force_err = 1'b0;
    unique case (state_q)
      MEM_IDLE: begin
        sel_d = 1'b0;
        if (hit && !inhibit) begin
          state_d  = MEM_SELECT;
          sel_d    = 1'b1;
          wr_d     = !bus.rd_nwr;
          burst_d  = bus.burst;
          maddr_d  = bus.addr;
          mwdata_d = bus.wdata;
        end
      end
      MEM_SELECT: begin
        if (inhibit || !bus.req) begin
          state_d = MEM_IDLE;
          sel_d   = 1'b0;
        end else begin
          state_d = MEM_ANSWER;
          answer  = 1'b1;
        end
      end
      MEM_ANSWER: begin
        // A burst cut short by the master costs one unused answer
        if (more_beats && !inhibit) begin
          maddr_d   = maddr_q + ADDR_W'(4);
          mwdata_d  = bus.wdata;
          answer    = 1'b1;
          force_err = dir_flip;
        end else begin
          // Single access done, burst ended by master, page end, error or takeover
          state_d = MEM_IDLE;
          sel_d   = 1'b0;
        end
      end
      default: begin
        state_d = MEM_IDLE;
        sel_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_q  <= MEM_IDLE;
      sel_q    <= 1'b0;
      wr_q     <= 1'b0;
      burst_q  <= 1'b0;
      maddr_q  <= '0;
      mwdata_q <= '0;
    end else begin
      state_q  <= state_d;
      sel_q    <= sel_d;
      wr_q     <= wr_d;
      burst_q  <= burst_d;
      maddr_q  <= maddr_d;
      mwdata_q <= mwdata_d;
    end
  end

  // Single-cycle array: data and status one cycle after select
  always_comb begin
    resp_d  = 1'b0;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    if (answer) begin
      resp_d  = !(mem_fault_in || force_err);
      err_d   = mem_fault_in || force_err;
      rdata_d = mem_rdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      resp_q  <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      resp_q  <= resp_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // Data and response enables only alongside ready/error
  assign bus.mem_ready    = resp_q;
  assign bus.mem_error    = err_q;
  assign bus.mem_resp_oe  = resp_q | err_q;
  assign bus.mem_rdata_oe = resp_q & !wr_q;
  assign bus.mem_rdata    = rdata_q;
  assign mem_select_out   = sel_q;
  assign mem_write_out    = wr_q;
  assign mem_addr_out     = maddr_q;
  assign mem_wdata_out    = mwdata_q;
  assign inhibit_out      = inhibit;
endmodule : memory_inhibit_end

// File: verification/emu_bus_monitor.sv
// Checks on the bus between the master end and the memory inhibit end.
// Assumes one clock domain; the bench instantiates it beside the bus.
`timescale 1ns/1ps
module emu_bus_monitor
  import emu_inhibit_pkg::*;
(
  input wire logic                   clk_sys_in,
  input wire logic                   rst_b_in,
  input wire logic                   req,
  input wire logic                   rd_nwr,
  input wire logic                   burst,
  input wire logic [ADDR_W-1:0]      addr,
  input wire logic [REQ_TYPE_W-1:0]  data_request_type,
  input wire logic [OPT_CODE_W-1:0]  option_code,
  input wire logic [TEST_CTRL_W-1:0] test_control,
  input wire logic                   locator_pin,
  input wire logic                   mem_rdata_oe,
  input wire logic                   mem_ready,
  input wire logic                   mem_error,
  input wire logic                   mem_resp_oe
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wire logic code_w = req && data_request_type == REQ_TYPE_INSTR_DATA
                      && option_code == OPT_EMU_ACCESS;
  wire logic ans_w = mem_ready || mem_error;

  chk_code_no_answer: assert property (code_w [*2] |=> !ans_w)
    else $error("memory answered an emulator code access");
  chk_pin_no_answer: assert property (locator_pin [*4] |=> !ans_w)
    else $error("memory answered while takeover pin driven");
  chk_data_with_ack: assert property (mem_rdata_oe |-> ans_w)
    else $error("data driven without ready or error");
  chk_resp_with_ack: assert property (mem_resp_oe |-> ans_w)
    else $error("response driven without ready or error");
  chk_normal_answered: assert property ($rose(req) && !locator_pin
    && !$past(locator_pin) && !$past(locator_pin, 2) && option_code == 3'h0
    && addr[31:16] == 16'h0 |-> ##[1:3] ans_w)
    else $error("plain access left unanswered");
  chk_emu_load_test: assert property (
    req && option_code == OPT_EMU_ACCESS
    |-> test_control == TEST_CTRL_LOAD_TEST && data_request_type == 2'h0)
    else $error("emulator code without load test mode");
  chk_burst_same_dir: assert property (req && burst && $past(req)
    |-> rd_nwr == $past(rd_nwr))
    else $error("burst mixed reads and writes");
  chk_burst_one_page: assert property (req && burst && $past(req)
    |-> addr[31:10] == $past(addr[31:10]))
    else $error("burst crossed a 1K page");

  cover property (code_w [*2]);
  cover property (locator_pin [*4] ##1 req);
  cover property ($rose(req) && burst);
  cover property (mem_error);
endmodule : emu_bus_monitor

// File: verification/emulator_access_memory_inhibit_tb.sv
// Bench joining the master end and the memory inhibit end over the bus.
// Assumes the bus interface and both design ends compile first.
`timescale 1ns/1ps
module emulator_access_memory_inhibit_tb;
  import emu_inhibit_pkg::*;
  logic        clk_sys_in = 0, rst_b_in = 0, start_in = 0, rd_nwr_in = 1;
  logic        burst_in = 0, emu_access_in = 0, takeover_pin_in = 0;
  logic        mem_fault_in = 0, busy_out, done_out, error_out;
  logic        mem_select_out, mem_write_out, inhibit_out;
  logic [31:0] addr_in = 0, wdata_in = 0, mem_rdata_in = 0;
  logic [31:0] seed = 32'h0000_0c82;
  logic [31:0] rdata_out, mem_addr_out, mem_wdata_out;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  int          failures = 0, n_tests = 0, cyc = 0;
  emu_bus_if bus ();
  bus_master_end u_bus_master_end (.clk_sys_in, .rst_b_in, .bus(bus.master),
    .start_in, .rd_nwr_in, .burst_in, .emu_access_in, .takeover_pin_in,
    .addr_in, .wdata_in, .busy_out, .done_out, .error_out, .rdata_out);
  memory_inhibit_end u_memory_inhibit_end (.clk_sys_in, .rst_b_in,
    .bus(bus.memory), .mem_rdata_in, .mem_fault_in, .mem_select_out,
    .mem_write_out, .mem_addr_out, .mem_wdata_out, .inhibit_out);
  emu_bus_monitor u_emu_bus_monitor (.clk_sys_in, .rst_b_in, .req(bus.req),
    .rd_nwr(bus.rd_nwr), .burst(bus.burst), .addr(bus.addr),
    .data_request_type(bus.data_request_type),
    .option_code(bus.option_code), .test_control(bus.test_control),
    .locator_pin(bus.locator_pin), .mem_rdata_oe(bus.mem_rdata_oe),
    .mem_ready(bus.mem_ready), .mem_error(bus.mem_error),
    .mem_resp_oe(bus.mem_resp_oe));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic do_reset();
    @(negedge clk_sys_in);
    rst_b_in = 0;
    repeat (6) @(negedge clk_sys_in);
    rst_b_in = 1;
  endtask : do_reset
  // Holds the request until the last beat is acked; notes each result
  task automatic acc(input logic rd, b, emu, flt, input int beats, lim);
    int k, got;
    logic sel, inh;
    got = 0;
    sel = 0;
    inh = emu | takeover_pin_in;
    @(negedge clk_sys_in);
    rd_nwr_in = rd; burst_in = b; emu_access_in = emu; mem_fault_in = flt;
    addr_in = rnd() & 32'h0000_03f0;
    mem_rdata_in = rnd();
    wdata_in = rnd();
    start_in = 1;
    for (k = 0; k < lim && got < beats; k++) begin
      @(negedge clk_sys_in);
      if (mem_select_out === 1'b1) sel = 1;
      if (bus.mem_ready === 1'b1 || bus.mem_error === 1'b1) begin
        got++;
        exp_q.push_back({rd & ~flt, flt, mem_rdata_in});
        if (got == beats) start_in = 0;
      end
    end
    start_in = 0;
    repeat (3) @(negedge clk_sys_in);
    chk(got, inh ? 0 : beats);
    chk(sel, !inh);
    if (inh) chk(inhibit_out, 1);
  endtask : acc
  always @(negedge clk_sys_in) begin
    if (rst_b_in && done_out === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0);
      else begin
        e = exp_q.pop_front();
        chk(error_out, e[32]);
        if (e[33]) chk(rdata_out, e[31:0]);
      end
    end
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    do_reset();
    for (int i = 0; i < 6; i++) acc(i[0], 0, 0, i == 3, 1, 20);
    acc(1, 1, 0, 0, 3, 30);
    acc(0, 1, 0, 0, 2, 30);
    acc(1, 0, 1, 0, 1, 10);
    do_reset();
    takeover_pin_in = 1;
    repeat (4) @(negedge clk_sys_in);
    acc(0, 0, 0, 0, 1, 10);
    takeover_pin_in = 0;
    do_reset();
    acc(1, 0, 0, 0, 1, 20);
    summarize();
  end
endmodule : emulator_access_memory_inhibit_tb
